/* File: xbr_map.svh */
// Constants for the external bus read cycle master
`ifndef XBR_MAP_SVH
`define XBR_MAP_SVH
`define XBR_SIZE_BYTE 2'h1
`define XBR_SIZE_WORD 2'h2
`define XBR_SIZE_LONG 2'h0
`define XBR_SIZE_LINE 2'h3
`define XBR_PORT_32 2'h0
`define XBR_PORT_16 2'h1
`define XBR_PORT_8 2'h2
`define XBR_MON_CYCLES_DEF 16
`endif

/* File: xbr_pkg.sv */
// Types for the external bus read cycle master
package xbr_pkg;
  typedef enum logic [1:0] {
    XBR_IDLE,
    XBR_START,
    XBR_WAIT
  } xbr_state_e;
endpackage : xbr_pkg

/* File: xbr_lane_sel.sv */
// Byte lane selection for one read beat
`timescale 1ns/10ps
`include "xbr_map.svh"
module xbr_lane_sel (
  input wire logic [1:0] port_i,
  input wire logic [1:0] offset_i,
  input wire logic [1:0] size_i,
  input wire logic [31:0] data_i,
  output logic [31:0] piece_o,
  output logic [3:0] valid_o
);
  wire logic is_byte = (size_i == `XBR_SIZE_BYTE);
  wire logic is_word = (size_i == `XBR_SIZE_WORD);
  wire logic [7:0] lane32 = (offset_i == 2'h0) ? data_i[31:24] :
                            (offset_i == 2'h1) ? data_i[23:16] :
                            (offset_i == 2'h2) ? data_i[15:8] : data_i[7:0];
  wire logic [7:0] lane16 = offset_i[0] ? data_i[23:16] : data_i[31:24];
  // Only lanes that carry the operand are passed; the rest read as zero
  assign piece_o = (port_i == `XBR_PORT_8) ? {24'h000000, data_i[31:24]} :
                   (port_i == `XBR_PORT_16) ?
                     (is_byte ? {24'h000000, lane16} : {16'h0000, data_i[31:16]}) :
                   is_byte ? {24'h000000, lane32} :
                   is_word ? {16'h0000, (offset_i[1] ? data_i[15:0] : data_i[31:16])} :
                   data_i;
  assign valid_o = (port_i == `XBR_PORT_8 || is_byte) ? 4'h1 :
                   (port_i == `XBR_PORT_16 || is_word) ? 4'h3 : 4'hf;
endmodule : xbr_lane_sel

/* File: xbr_master.sv */
// Read-cycle master of the external synchronous bus
// How it works
// - Address bits 31..2 give longword base, bits 1..0 the byte offset.
// - Lanes outside the operand are ignored by the master.
// - Invalid size and offset pairs for the port are never issued.
// - First clock drives address, kind, mode, read high and start strobe.
// - Longword transfers drive size code 00 in the first clock on a 32-bit port or when bursting.
// - Mode signal shows code/data first clock, supervisor in the second.
// - Start strobe lasts exactly one clock.
// - Acknowledge sampled at end of second clock; data latched when set.
// - Without acknowledge, wait states follow, resampled every edge.
// - Enabled monitor timeout ends the cycle with a bus error.
// - Longword on 16-bit port is two word reads, offsets 0 then 2, or 2 then 0 when it starts at offset 2.
// - Size code: byte 01, word 10, long 00, line 11; narrow pieces if inhibited.
// - Port width is taken once when the request is accepted, and held for all its bus cycles.
`timescale 1ns/10ps
`include "xbr_map.svh"
module xbr_master #(
  parameter int MON_W = 16
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic [31:0] REQ_ADDR_I,
  input wire logic [1:0] REQ_SIZE_I,
  input wire logic [1:0] REQ_KIND_I,
  input wire logic REQ_CODE_I,
  input wire logic REQ_SUPER_I,
  input wire logic [1:0] PORT_WIDTH_I,
  input wire logic BURST_EN_I,
  input wire logic MON_EN_I,
  input wire logic [MON_W-1:0] MON_CYCLES_I,
  output logic [31:0] ADDR_O,
  output logic [1:0] TRANSFER_KIND_O,
  output logic ACCESS_KIND_MODE_O,
  output logic READ_NOT_WRITE_O,
  output logic [1:0] SIZE_CODE_O,
  output logic XFER_BEGIN_STROBE_N_O,
  input wire logic XFER_ACKNOWLEDGE_N_I,
  input wire logic [31:0] DATA_I,
  output logic DONE_O,
  output logic BUS_ERROR_O,
  output logic [31:0] RDATA_O
);
  xbr_pkg::xbr_state_e state;
  xbr_pkg::xbr_state_e next_state;
  logic [31:0] addr;
  logic [1:0] size_op;
  logic [1:0] port;
  logic [1:0] kind;
  logic code;
  logic priv;
  logic burst;
  logic [1:0] beats_left;
  logic [31:0] acc;
  logic [MON_W-1:0] mon_cnt;
  logic [31:0] rdata;
  logic done;
  logic berr;
  logic [31:0] piece;
  logic [3:0] piece_valid;

  wire logic idle = (state == xbr_pkg::XBR_IDLE);
  wire logic ack = (state == xbr_pkg::XBR_WAIT) && !XFER_ACKNOWLEDGE_N_I;
  wire logic timeout = (state == xbr_pkg::XBR_WAIT) && !ack && MON_EN_I &&
                       (mon_cnt >= MON_CYCLES_I);
  wire logic req_long = (REQ_SIZE_I == `XBR_SIZE_LONG) || (REQ_SIZE_I == `XBR_SIZE_LINE);
  wire logic req_word = (REQ_SIZE_I == `XBR_SIZE_WORD);
  // Misaligned requests for the given port are refused
  wire logic req_ok = !((req_word && REQ_ADDR_I[0] && PORT_WIDTH_I != `XBR_PORT_8) ||
                        (req_long && REQ_ADDR_I[1:0] != 2'h0 && PORT_WIDTH_I == `XBR_PORT_32) ||
                        (req_long && REQ_ADDR_I[0] && PORT_WIDTH_I == `XBR_PORT_16));
  wire logic take = idle && REQ_VALID_I && req_ok;
  wire logic [1:0] req_beats = !req_long ?
                               ((req_word && PORT_WIDTH_I == `XBR_PORT_8) ? 2'h1 : 2'h0) :
                               (PORT_WIDTH_I == `XBR_PORT_32) ? 2'h0 :
                               (PORT_WIDTH_I == `XBR_PORT_16) ? 2'h1 : 2'h3;
  wire logic [1:0] step = (port == `XBR_PORT_16) ? 2'h2 : 2'h1;
  wire logic last = (beats_left == 2'h0);
  wire logic [1:0] piece_size = (port == `XBR_PORT_8) ? `XBR_SIZE_BYTE :
                                (port == `XBR_PORT_16 && size_op != `XBR_SIZE_BYTE) ?
                                `XBR_SIZE_WORD :
                                // Without bursting a line on a wide port goes out as a longword
                                (size_op == `XBR_SIZE_LINE) ? `XBR_SIZE_LONG : size_op;
  wire logic [1:0] size_drive = burst ? size_op : piece_size;
  wire logic [31:0] merged = (piece_valid == 4'h1) ? {acc[23:0], piece[7:0]} :
                             (piece_valid == 4'h3) ? {acc[15:0], piece[15:0]} : piece;

  assign REQ_READY_O = idle;
  assign ADDR_O = addr;
  assign TRANSFER_KIND_O = kind;
  assign READ_NOT_WRITE_O = 1'b1;
  assign SIZE_CODE_O = size_drive;
  assign ACCESS_KIND_MODE_O = (state == xbr_pkg::XBR_START) ? code : priv;
  assign XFER_BEGIN_STROBE_N_O = !(state == xbr_pkg::XBR_START);
  assign DONE_O = done;
  assign BUS_ERROR_O = berr;
  assign RDATA_O = rdata;

  xbr_lane_sel u_lane (
    .port_i(port),
    .offset_i(addr[1:0]),
    .size_i(piece_size),
    .data_i(DATA_I),
    .piece_o(piece),
    .valid_o(piece_valid)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      xbr_pkg::XBR_IDLE: if (take) next_state = xbr_pkg::XBR_START;
      xbr_pkg::XBR_START: next_state = xbr_pkg::XBR_WAIT;
      xbr_pkg::XBR_WAIT:
        if (timeout) next_state = xbr_pkg::XBR_IDLE;
        else if (ack) next_state = last ? xbr_pkg::XBR_IDLE : xbr_pkg::XBR_START;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      state <= xbr_pkg::XBR_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      addr <= 32'h00000000;
      size_op <= `XBR_SIZE_LONG;
      port <= `XBR_PORT_32;
      kind <= 2'h0;
      code <= 1'b0;
      priv <= 1'b0;
      burst <= 1'b0;
      beats_left <= 2'h0;
    end
    else if (take)
    begin
      addr <= REQ_ADDR_I;
      size_op <= REQ_SIZE_I;
      port <= PORT_WIDTH_I;
      kind <= REQ_KIND_I;
      code <= REQ_CODE_I;
      priv <= REQ_SUPER_I;
      burst <= BURST_EN_I;
      beats_left <= req_beats;
    end
    else if (ack && !last)
    begin
      addr <= {addr[31:2], addr[1:0] + step};
      beats_left <= beats_left - 2'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      mon_cnt <= '0;
    else if (state == xbr_pkg::XBR_START)
      mon_cnt <= '0;
    else if (state == xbr_pkg::XBR_WAIT)
      mon_cnt <= mon_cnt + 1'b1;
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      acc <= 32'h00000000;
      rdata <= 32'h00000000;
      done <= 1'b0;
      berr <= 1'b0;
    end
    else
    begin
      done <= ack && last;
      berr <= timeout;
      if (take)
        acc <= 32'h00000000;
      else if (ack)
        acc <= merged;
      if (ack && last)
        rdata <= merged;
    end
  end

  start_one_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !XFER_BEGIN_STROBE_N_O |=> XFER_BEGIN_STROBE_N_O) else $error("strobe held");
  read_high_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    READ_NOT_WRITE_O) else $error("not read");
  long_size_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (!XFER_BEGIN_STROBE_N_O && size_op == `XBR_SIZE_LONG && (burst || port == `XBR_PORT_32))
    |-> SIZE_CODE_O == 2'h0) else $error("long size");
  mode_super_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !XFER_BEGIN_STROBE_N_O |=> ACCESS_KIND_MODE_O == priv) else $error("mode phase2");
  ack_done_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (ack && last) |=> DONE_O && RDATA_O == $past(merged)) else $error("no done");
  wait_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (state == xbr_pkg::XBR_WAIT && XFER_ACKNOWLEDGE_N_I && !timeout)
    |=> state == xbr_pkg::XBR_WAIT) else $error("wait lost");
  timeout_err_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    timeout |=> BUS_ERROR_O && idle) else $error("no bus error");
  align_ok_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (!XFER_BEGIN_STROBE_N_O && port == `XBR_PORT_32 && size_drive == `XBR_SIZE_LONG)
    |-> ADDR_O[1:0] == 2'h0) else $error("misaligned");
  step_addr_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (ack && !last) |=> ADDR_O[1:0] == $past(ADDR_O[1:0]) + $past(step)) else $error("step");
  c_wait_c: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    state == xbr_pkg::XBR_WAIT ##1 state == xbr_pkg::XBR_WAIT ##1 DONE_O);
  c_split_c: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    ack && !last && port == `XBR_PORT_8);
  c_err_c: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I) BUS_ERROR_O);
endmodule : xbr_master

/* File: xbr_slave.sv */
// Behavioural read slave on the far side of the external bus
`timescale 1ns/10ps
module xbr_slave (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic strobe_n_i,
  input wire logic [31:0] addr_i,
  input wire logic [1:0] size_i,
  input wire logic [1:0] port_i,
  input wire logic [7:0] wait_i,
  output logic ack_n_o,
  output logic [31:0] data_o
);
  logic [31:0] a;
  logic [1:0] sz;
  logic [7:0] cnt;
  wire logic st = !strobe_n_i;
  wire logic [31:0] ca = st ? addr_i : a;
  wire logic [1:0] cs = st ? size_i : sz;
  wire logic fire = st ? (wait_i == 8'h0) : (cnt == 8'h1);
  function automatic logic [7:0] mem_byte(input logic [31:0] x);
    return (x[7:0] * 8'h1d) ^ x[15:8] ^ 8'ha5;
  endfunction : mem_byte
  // Operand bytes on their lanes, junk on every other lane
  function automatic logic [31:0] lanes(input logic [31:0] x, input logic [1:0] s, p);
    logic [31:0] d;
    int o;
    int n;
    n = (s == 2'h1) ? 1 : (s == 2'h2) ? 2 : 4;
    for (int k = 0; k < 4; k++)
    begin
      o = (p == 2'h0) ? k : (p == 2'h1 && k < 2) ? int'(x[1] * 2) + k :
          (p == 2'h2 && k == 0) ? int'(x[1:0]) : 9;
      d[31-8*k -: 8] = (o >= x[1:0] && o < x[1:0] + n && o < 4) ?
          mem_byte({x[31:2], o[1:0]}) : ~mem_byte(x + k);
    end
    return d;
  endfunction : lanes
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_n_o <= 1'b1;
      data_o <= 32'h0;
      cnt <= 8'h0;
    end
    else
    begin
      ack_n_o <= 1'b1;
      data_o <= ~data_o;
      if (st)
      begin
        a <= addr_i;
        sz <= size_i;
        cnt <= wait_i;
      end
      else if (cnt != 8'h0)
        cnt <= cnt - 8'h1;
      if (fire)
      begin
        ack_n_o <= 1'b0;
        data_o <= lanes(ca, cs, port_i);
      end
    end
  end
endmodule : xbr_slave

/* File: xbr_master_tb.sv */
// Self-checking testbench for the read-cycle master
`timescale 1ns/10ps
module xbr_master_tb;
  logic clk = 0, rst_n = 0, valid = 0, code = 0, sup = 0, burst = 0, mon = 0, hung = 0, ps = 0;
  logic [31:0] addr = 0, a_o, rdata, data;
  logic [1:0] size = 0, kind = 0, port = 0, kind_o, sc;
  logic ready, mode, rnw, stb_n, ack_n, done, err;
  logic [7:0] w = 0;
  int seed = 26, fail_count = 0, cmp_count = 0, nb = 0;
  initial forever #2 clk = ~clk;
  xbr_master i_xbr_master (.CLK_SYS_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(valid),
    .REQ_READY_O(ready), .REQ_ADDR_I(addr), .REQ_SIZE_I(size), .REQ_KIND_I(kind),
    .REQ_CODE_I(code), .REQ_SUPER_I(sup), .PORT_WIDTH_I(port), .BURST_EN_I(burst),
    .MON_EN_I(mon), .MON_CYCLES_I(16'h4), .ADDR_O(a_o), .TRANSFER_KIND_O(kind_o),
    .ACCESS_KIND_MODE_O(mode), .READ_NOT_WRITE_O(rnw), .SIZE_CODE_O(sc),
    .XFER_BEGIN_STROBE_N_O(stb_n), .XFER_ACKNOWLEDGE_N_I(ack_n), .DATA_I(data),
    .DONE_O(done), .BUS_ERROR_O(err), .RDATA_O(rdata));
  xbr_slave i_xbr_slave (.clk_i(clk), .rst_n_i(rst_n), .strobe_n_i(stb_n), .addr_i(a_o),
    .size_i(sc), .port_i(port), .wait_i(w), .ack_n_o(ack_n), .data_o(data));
  task chk(input logic [31:0] s, e, input string m);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  function automatic int nbytes(input logic [1:0] s);
    return s == 2'h1 ? 1 : s == 2'h2 ? 2 : 4;
  endfunction : nbytes
  function automatic logic [1:0] esz(input logic [1:0] s, p, input logic b);
    return p == 2'h0 ? ((s == 2'h3 && !b) ? 2'h0 : s) :
           b ? s : (p == 2'h2 || s == 2'h1) ? 2'h1 : 2'h2;
  endfunction : esz
  always @(posedge clk)
  begin
    if (ps)
      chk({stb_n, mode}, {1'b1, sup}, "second clock");
    if (!stb_n)
    begin
      chk(a_o, {addr[31:2], 2'(addr[1:0] + nb * (port == 2'h1 ? 2 : 1))}, "addr");
      chk({rnw, kind_o, mode}, {1'b1, kind, code}, "control");
      chk(sc, esz(size, port, burst), "size code");
      nb++;
    end
    ps = !stb_n;
  end
  task xfer(input logic [31:0] ad, input logic [1:0] sz, p, input int wt);
    int t;
    int n;
    logic [31:0] e;
    n = nbytes(sz);
    e = 0;
    @(negedge clk);
    {addr, size, port, w, valid, nb} = {ad, sz, p, 8'(wt), 1'b1, 32'h0};
    {kind, code, sup, burst} = 5'($random(seed));
    mon = wt > 20 ? 1'b1 : 1'($random(seed));
    @(negedge clk);
    valid = 0;
    t = 1;
    while (done !== 1'b1 && err !== 1'b1 && t < 300)
    begin
      @(posedge clk);
      #1 t++;
    end
    hung = t >= 300;
    for (int i = 0; i < n; i++)
      e = {e[23:0], i_xbr_slave.mem_byte(ad + i)};
    if (wt > 20)
      chk({err, done}, 2'h2, "monitor timeout");
    else
    begin
      chk({err, done}, 2'h1, "completion");
      chk(rdata, e, "read data");
      chk(nb, p == 2'h0 ? 1 : p == 2'h1 ? (n == 4 ? 2 : 1) : n, "beats");
      if (nb == 1)
        chk(t, 3 + wt, "latency");
    end
  endtask : xfer
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    logic [1:0] s;
    logic [1:0] p;
    logic [31:0] ad;
    repeat (20) @(posedge clk);
    @(negedge clk) rst_n = 1;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk);
      {addr, size, port, valid, nb} = {i ? 32'h102 : 32'h101, i ? 2'h0 : 2'h2, 2'h0, 1'b1, 32'h0};
      repeat (8) @(negedge clk);
      valid = 0;
      chk({ready, 8'(nb)}, 9'h100, "illegal request");
    end
    xfer(32'h1000, 2'h0, 2'h0, 0);
    xfer(32'h2000, 2'h0, 2'h1, 1);
    xfer(32'h3000, 2'h0, 2'h2, 0);
    xfer(32'h5000, 2'h0, 2'h0, 40);
    for (int i = 0; i < 80 && !hung; i++)
    begin
      p = 2'({$random(seed)} % 3);
      s = 2'($random(seed));
      ad = $random(seed);
      if (s == 2'h3 && p != 2'h0)
        s = 2'h0;
      ad[1:0] = s == 2'h1 ? ad[1:0] : s != 2'h2 ? 2'h0 :
                p == 2'h2 ? 2'({$random(seed)} % 3) : {ad[1], 1'b0};
      xfer(ad, s, p, {$random(seed)} % 3);
    end
    if (hung)
      fail_count++;
    wrap_up;
  end
endmodule : xbr_master_tb
